// [rtl/port_b_bus_match.sv]
`timescale 1ns/10ps
`include "bus_match_cfg.svh"
module port_b_bus_match (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      master_reset_first,
    input  wire logic                      partial_reset,
    input  wire logic                      bus_match_select,
    input  wire logic                      size_select,
    input  wire logic                      endian_select,
    input  wire logic                      b_wr_en,
    input  wire logic [`LONG_W-1:0]        port_b_bus_in,
    input  wire logic                      b_rd_en,
    output logic      [`LONG_W-1:0]        port_b_bus_out,
    output logic                           b_rd_valid,
    output logic                           b_to_a_push,
    output logic      [`LONG_W-1:0]        b_to_a_data,
    output logic                           a_to_b_pop,
    input  wire logic [`LONG_W-1:0]        a_to_b_data,
    input  wire logic                      a_to_b_nonempty,
    output logic                           big_endian_out
);
    import bus_match_pkg::*;

    // Strap pins and the master and partial reset pins pass two flops before any logic reads them; rst is used directly
    logic [1:0] bm_sync_reg, bm_sync_next, sz_sync_reg, sz_sync_next;
    logic [1:0] mr_sync_reg, mr_sync_next, pr_sync_reg, pr_sync_next;
    logic [1:0] be_sync_reg, be_sync_next;
    logic       big_endian_reg, big_endian_next;
    logic [1:0] wr_piece_reg, wr_piece_next, rd_piece_reg, rd_piece_next;
    logic [`LONG_W-1:0] wr_hold_reg, wr_hold_next, rd_hold_reg, rd_hold_next;
    logic [`LONG_W-1:0] out_reg, out_next, push_data_reg, push_data_next;
    logic       push_reg, push_next, valid_reg, valid_next;
    rd_state_t  rd_state_reg, rd_state_next;
    width_mode_t mode;
    logic [1:0] last_piece, wr_lane, rd_lane;
    logic       clear;
    logic [`LANE_W-1:0] rd_byte;
    logic [`WORD_W-1:0] rd_word;

    assign clear = rst | mr_sync_reg[1] | pr_sync_reg[1];

    always_comb begin
        mode = SIZE_LONG;
        if (bm_sync_reg[1]) begin
            mode = sz_sync_reg[1] ? SIZE_BYTE : SIZE_WORD;
        end
        last_piece = (mode == SIZE_BYTE) ? `PIECES_BYTE : `PIECES_WORD;
    end

    lane_order u_wr_lane (
        .piece      (wr_piece_reg),
        .big_endian (big_endian_reg),
        .byte_mode  (mode == SIZE_BYTE),
        .lane       (wr_lane)
    );
    lane_order u_rd_lane (
        .piece      (rd_piece_reg),
        .big_endian (big_endian_reg),
        .byte_mode  (mode == SIZE_BYTE),
        .lane       (rd_lane)
    );

    always_comb begin
        bm_sync_next    = {bm_sync_reg[0], bus_match_select};
        sz_sync_next    = {sz_sync_reg[0], size_select};
        mr_sync_next    = {mr_sync_reg[0], master_reset_first};
        pr_sync_next    = {pr_sync_reg[0], partial_reset};
        be_sync_next    = {be_sync_reg[0], endian_select};
        big_endian_next = big_endian_reg;
        // Endian strap and master reset share the same sync delay
        if (mr_sync_reg[1]) begin
            big_endian_next = be_sync_reg[1];
        end
    end

    // Write packing
    always_comb begin
        wr_piece_next  = wr_piece_reg;
        wr_hold_next   = wr_hold_reg;
        push_next      = 1'b0;
        push_data_next = push_data_reg;
        if (clear) begin
            wr_piece_next = 2'h0;
            wr_hold_next  = '0;
        end else if (b_wr_en) begin
            if (mode == SIZE_LONG) begin
                push_next      = 1'b1;
                push_data_next = port_b_bus_in;
            end else begin
                if (mode == SIZE_BYTE) begin
                    // Only B8-B0 is used
                    wr_hold_next[wr_lane*`LANE_W +: `LANE_W] = port_b_bus_in[`LANE_W-1:0];
                end else begin
                    wr_hold_next[wr_lane*`LANE_W +: `WORD_W] = port_b_bus_in[`WORD_W-1:0];
                end
                if (wr_piece_reg == last_piece) begin
                    push_next      = 1'b1;
                    push_data_next = wr_hold_next;
                    wr_piece_next  = 2'h0;
                end else begin
                    wr_piece_next = 2'(wr_piece_reg + 2'h1);
                end
            end
        end
    end

    // Read unpacking
    always_comb begin
        rd_state_next = rd_state_reg;
        rd_piece_next = rd_piece_reg;
        rd_hold_next  = rd_hold_reg;
        out_next      = out_reg;
        valid_next    = 1'b0;
        a_to_b_pop    = 1'b0;
        rd_byte       = rd_hold_reg[rd_lane*`LANE_W +: `LANE_W];
        rd_word       = rd_hold_reg[rd_lane*`LANE_W +: `WORD_W];
        if (clear) begin
            rd_state_next = RD_IDLE;
            rd_piece_next = 2'h0;
            rd_hold_next  = '0;
        end else if (b_rd_en) begin
            case (rd_state_reg)
                RD_IDLE: begin
                    if (a_to_b_nonempty) begin
                        a_to_b_pop = 1'b1;
                        valid_next = 1'b1;
                        if (mode == SIZE_LONG) begin
                            out_next = a_to_b_data;
                        end else begin
                            rd_hold_next  = a_to_b_data;
                            rd_state_next = RD_HOLD;
                            rd_piece_next = 2'h1;
                            if (mode == SIZE_BYTE) begin
                                out_next = {27'h0000000, a_to_b_data[(big_endian_reg ? 3 : 0)
                                           *`LANE_W +: `LANE_W]};
                            end else begin
                                out_next = {18'h00000, a_to_b_data[(big_endian_reg ? 2 : 0)
                                           *`LANE_W +: `WORD_W]};
                            end
                        end
                    end
                end
                RD_HOLD: begin
                    valid_next = 1'b1;
                    if (mode == SIZE_BYTE) begin
                        out_next = {27'h0000000, rd_byte};
                    end else begin
                        out_next = {18'h00000, rd_word};
                    end
                    if (rd_piece_reg == last_piece) begin
                        rd_state_next = RD_IDLE;
                        rd_piece_next = 2'h0;
                    end else begin
                        rd_piece_next = 2'(rd_piece_reg + 2'h1);
                    end
                end
                default: rd_state_next = RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bm_sync_reg    <= 2'h0;
            sz_sync_reg    <= 2'h0;
            mr_sync_reg    <= 2'h0;
            pr_sync_reg    <= 2'h0;
            be_sync_reg    <= 2'h0;
            big_endian_reg <= `ENDIAN_RST;
            wr_piece_reg   <= 2'h0;
            wr_hold_reg    <= '0;
            push_reg       <= 1'b0;
            push_data_reg  <= '0;
            rd_state_reg   <= RD_IDLE;
            rd_piece_reg   <= 2'h0;
            rd_hold_reg    <= '0;
            out_reg        <= '0;
            valid_reg      <= 1'b0;
        end else begin
            bm_sync_reg    <= bm_sync_next;
            sz_sync_reg    <= sz_sync_next;
            mr_sync_reg    <= mr_sync_next;
            pr_sync_reg    <= pr_sync_next;
            be_sync_reg    <= be_sync_next;
            big_endian_reg <= big_endian_next;
            wr_piece_reg   <= wr_piece_next;
            wr_hold_reg    <= wr_hold_next;
            push_reg       <= push_next;
            push_data_reg  <= push_data_next;
            rd_state_reg   <= rd_state_next;
            rd_piece_reg   <= rd_piece_next;
            rd_hold_reg    <= rd_hold_next;
            out_reg        <= out_next;
            valid_reg      <= valid_next;
        end
    end

    assign port_b_bus_out = out_reg;
    assign b_rd_valid     = valid_reg;
    assign b_to_a_push    = push_reg;
    assign b_to_a_data    = push_data_reg;
    assign big_endian_out = big_endian_reg;

    sequence s_long_write;
        b_wr_en && !clear && mode == SIZE_LONG;
    endsequence

    a_long_write_pass: assert property (@(posedge clk_sys) disable iff (rst)
        s_long_write |=> b_to_a_push && b_to_a_data == $past(port_b_bus_in))
        else $error("long write not passed through");
    a_word_commit: assert property (@(posedge clk_sys) disable iff (rst)
        (b_wr_en && !clear && mode == SIZE_WORD && wr_piece_reg == 2'h0)
        |=> !b_to_a_push)
        else $error("word commit on first piece");
    a_byte_commit: assert property (@(posedge clk_sys) disable iff (rst)
        (b_wr_en && !clear && mode == SIZE_BYTE && wr_piece_reg == 2'h3) |=> b_to_a_push)
        else $error("byte commit missing on fourth piece");
    a_long_read: assert property (@(posedge clk_sys) disable iff (rst)
        (a_to_b_pop && mode == SIZE_LONG) |=> port_b_bus_out == $past(a_to_b_data))
        else $error("long read mismatch");
    a_hold_no_pop: assert property (@(posedge clk_sys) disable iff (rst)
        rd_state_reg == RD_HOLD |-> !a_to_b_pop and ((b_rd_en && !clear) |=> b_rd_valid))
        else $error("fetch while pieces held");
    a_endian_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(mr_sync_reg[1]) |-> $stable(big_endian_reg))
        else $error("endian changed outside reset");
    a_reset_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (mr_sync_reg[1] || pr_sync_reg[1]) |=> wr_piece_reg == 2'h0 && rd_piece_reg == 2'h0)
        else $error("pieces not cleared");
    a_byte_upper: assert property (@(posedge clk_sys) disable iff (rst)
        (valid_reg && mode == SIZE_BYTE && $stable(mode)) |-> port_b_bus_out[35:9] == 27'h0)
        else $error("byte read upper lanes driven");
endmodule : port_b_bus_match

// [rtl/bus_match_cfg.svh]
// How it works
// - Long mode writes whole bus unchanged
// - Word writes pair, endian picks half order
// - Byte writes four, endian picks lane order
// - Long mode reads whole stored word
// - Word reads two halves, endian order
// - Upper half driven to zero on word reads
// - Upper lanes driven to zero on byte reads
// - Endian latched only during master reset
// - Last piece commits assembled word
// - Lanes outside width are ignored
// - Held pieces drain before next fetch
// - Byte reads four, endian order
`ifndef BUS_MATCH_CFG_SVH
`define BUS_MATCH_CFG_SVH
`define LANE_W        9
`define LONG_W        36
`define WORD_W        18
`define PIECES_WORD   2'h1
`define PIECES_BYTE   2'h3
`define ENDIAN_RST    1'b1
`endif

// [rtl/bus_match_pkg.sv]
package bus_match_pkg;
    typedef enum logic [1:0] {SIZE_LONG, SIZE_WORD, SIZE_BYTE} width_mode_t;
    typedef enum {RD_IDLE, RD_HOLD} rd_state_t;
endpackage : bus_match_pkg

// [rtl/lane_order.sv]
`timescale 1ns/10ps
`include "bus_match_cfg.svh"
// Maps a piece count to the 9-bit lane index it occupies in the long word
module lane_order (
    input  wire logic [1:0] piece,
    input  wire logic       big_endian,
    input  wire logic       byte_mode,
    output logic      [1:0] lane
);
    always_comb begin
        if (byte_mode) begin
            lane = big_endian ? 2'(2'h3 - piece) : piece;
        end else begin
            lane = big_endian ? 2'({~piece[0], 1'b0}) : 2'({piece[0], 1'b0});
        end
    end
endmodule : lane_order

// [tb/a_to_b_queue_model.sv]
`timescale 1ns/10ps
module a_to_b_queue_model (
    input  wire logic        clk_sys,
    input  wire logic        load_en,
    input  wire logic [35:0] load_data,
    input  wire logic        a_to_b_pop,
    output logic      [35:0] a_to_b_data = 36'h0,
    output logic             a_to_b_nonempty = 1'b0
);
    logic [35:0] q[$];
    logic [35:0] last = 36'h0;
    // An emptied queue shows the inverse of the last word, never stale data
    always @(posedge clk_sys) begin
        if (a_to_b_pop && q.size() != 0) begin
            last = q.pop_front();
        end
        if (load_en) begin
            q.push_back(load_data);
        end
        a_to_b_nonempty <= q.size() != 0;
        a_to_b_data     <= (q.size() != 0) ? q[0] : ~last;
    end
endmodule : a_to_b_queue_model

// [tb/port_b_bus_width_matching_tb_top.sv]
`timescale 1ns/10ps
`include "bus_match_cfg.svh"
module port_b_bus_width_matching_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        master_reset_first = 1'b0;
    logic        partial_reset = 1'b0;
    logic        bus_match_select = 1'b0;
    logic        size_select = 1'b0;
    logic        endian_select = 1'b1;
    logic        b_wr_en = 1'b0;
    logic        b_rd_en = 1'b0;
    logic        load_en = 1'b0;
    logic [35:0] port_b_bus_in = 36'h0;
    logic [35:0] load_data = 36'h0;
    logic [35:0] port_b_bus_out, b_to_a_data, a_to_b_data;
    logic        b_rd_valid, b_to_a_push, a_to_b_pop, a_to_b_nonempty, big_endian_out;
    logic [35:0] wq[$];
    logic [35:0] rq[$];
    int          fail_count = 0;
    int          total_checks = 0;

    port_b_bus_match dut (.clk_sys, .rst, .master_reset_first, .partial_reset,
        .bus_match_select, .size_select, .endian_select, .b_wr_en, .port_b_bus_in,
        .b_rd_en, .port_b_bus_out, .b_rd_valid, .b_to_a_push, .b_to_a_data,
        .a_to_b_pop, .a_to_b_data, .a_to_b_nonempty, .big_endian_out);
    a_to_b_queue_model far (.clk_sys, .load_en, .load_data, .a_to_b_pop,
        .a_to_b_data, .a_to_b_nonempty);

    initial forever #2.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (b_to_a_push === 1'b1) wq.push_back(b_to_a_data);
        if (b_rd_valid === 1'b1) rq.push_back(port_b_bus_out);
    end

    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic setup(input logic bm, input logic sz, input logic be);
        bus_match_select   <= bm;
        size_select        <= sz;
        endian_select      <= be;
        master_reset_first <= 1'b1;
        repeat (3) @(posedge clk_sys);
        master_reset_first <= 1'b0;
        endian_select      <= ~be;
        @(posedge clk_sys);
        #1;
        chk("endian", {35'h0, be}, {35'h0, big_endian_out});
        wq.delete();
        rq.delete();
        @(posedge clk_sys);
    endtask : setup

    // Pieces carry junk outside the selected width; endian_select is flipped meanwhile
    task automatic xfer(input int n, input int w, input logic be, input logic [35:0] lw);
        logic [35:0] m;
        logic [35:0] v;
        int          idx;
        m = (36'h1 << w) - 36'h1;
        for (int k = 0; k < n; k++) begin
            idx = be ? n - 1 - k : k;
            b_wr_en       <= 1'b1;
            port_b_bus_in <= ((lw >> (idx * w)) & m) | ~m;
            @(posedge clk_sys);
        end
        b_wr_en   <= 1'b0;
        load_en   <= 1'b1;
        load_data <= lw;
        @(posedge clk_sys);
        load_data <= ~lw;
        @(posedge clk_sys);
        load_en <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("pushes", 36'(1), 36'(wq.size()));
        chk("committed", lw, wq[0]);
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < n; k++) begin
                b_rd_en <= 1'b1;
                @(posedge clk_sys);
            end
            b_rd_en <= 1'b0;
            repeat (2) @(posedge clk_sys);
            #1;
            if (r == 0) chk("nonempty", 36'h1, {35'h0, a_to_b_nonempty});
            @(posedge clk_sys);
        end
        chk("reads", 36'(2 * n), 36'(rq.size()));
        for (int j = 0; j < 2 * n && j < rq.size(); j++) begin
            v   = (j < n) ? lw : ~lw;
            idx = be ? n - 1 - (j % n) : j % n;
            chk("piece", (v >> (idx * w)) & m, rq[j] & m);
        end
    endtask : xfer

    task automatic t_long;
        setup(1'b0, 1'b0, 1'b0);
        xfer(1, 36, 1'b0, 36'h1A5C396E1);
        $display("test long done");
    endtask : t_long

    task automatic t_word;
        setup(1'b1, 1'b0, 1'b1);
        xfer(2, 18, 1'b1, 36'h2B6D4A7F3);
        setup(1'b1, 1'b0, 1'b0);
        xfer(2, 18, 1'b0, 36'h2B6D4A7F3);
        $display("test word done");
    endtask : t_word

    task automatic t_byte;
        setup(1'b1, 1'b1, 1'b1);
        xfer(4, 9, 1'b1, 36'h3C1E0F785);
        setup(1'b1, 1'b1, 1'b0);
        xfer(4, 9, 1'b0, 36'h3C1E0F785);
        $display("test byte done");
    endtask : t_byte

    task automatic t_partial;
        setup(1'b1, 1'b1, 1'b1);
        b_wr_en       <= 1'b1;
        port_b_bus_in <= 36'h0000001FF;
        @(posedge clk_sys);
        b_wr_en       <= 1'b0;
        partial_reset <= 1'b1;
        @(posedge clk_sys);
        partial_reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        xfer(4, 9, 1'b1, 36'h0F0E1D2C3);
        $display("test partial reset done");
    endtask : t_partial

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("endian default", 36'h1, {35'h0, big_endian_out});
        @(posedge clk_sys);
        t_long();
        t_word();
        t_byte();
        t_partial();
        report_and_stop();
    end
endmodule : port_b_bus_width_matching_tb_top
